// >>> include/sps_pkg.sv
// package of constants for the serial port pin select block
package sps_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0] SPS_OFF_DIR    = 4'h0;  // direction bits, write only
  localparam logic [3:0] SPS_OFF_DATA   = 4'h1;  // output data bits
  localparam logic [3:0] SPS_OFF_PORT   = 4'h2;  // port read
  localparam logic [3:0] SPS_OFF_ODR    = 4'h3;  // open-drain control bits
  localparam logic [3:0] SPS_OFF_SER0   = 4'h4;  // channel 0 serial settings
  localparam logic [3:0] SPS_OFF_SER1   = 4'h5;  // channel 1 serial settings
  localparam logic [3:0] SPS_OFF_FUNC   = 4'h6;  // selected pin functions

  // ****************************************
  // widths, fields and reset values
  // ****************************************
  localparam int unsigned SPS_PINS      = 6;
  localparam int unsigned SPS_DW        = 8;
  localparam logic [5:0]  SPS_DIR_RST   = 6'h00;
  localparam logic [5:0]  SPS_DATA_RST  = 6'h00;
  localparam logic [5:0]  SPS_ODR_RST   = 6'h00;
  localparam logic [4:0]  SPS_SER_RST   = 5'h00;
  localparam int unsigned SPS_SER_SYNC  = 0;  // synchronous mode select
  localparam int unsigned SPS_SER_CLOCK_ENABLE_LOW  = 1;  // clock_enable_low
  localparam int unsigned SPS_SER_CLOCK_ENABLE_HIGH  = 2;  // clock_enable_high
  localparam int unsigned SPS_SER_RXEN  = 3;  // receive_enable
  localparam int unsigned SPS_SER_TXEN  = 4;  // transmit_enable

  // ****************************************
  // clock pin modes
  // ****************************************
  typedef enum logic [2:0] {
    SPS_CLK_GPIO = 3'b001,
    SPS_CLK_OUT  = 3'b010,
    SPS_CLK_IN   = 3'b100
  } sps_clk_mode_e;

endpackage

// >>> logic/sps_pin_cell.sv
// one pin cell: output drive, open-drain and pin sampling
`timescale 1ns/100ps
module sps_pin_cell
  import sps_pkg::*;
(
  input  wire logic clk_i,       // system clock
  input  wire logic rst_n_i,     // async reset, active low
  input  wire logic drive_i,     // pin acts as output
  input  wire logic level_i,     // level to drive
  input  wire logic od_i,        // open-drain select
  input  wire logic pin_i,       // pin level in
  output logic      pin_o,       // pin level out
  output logic      pin_oe_n_o,  // output enable, low drives
  output logic      sample_o     // registered pin sample
);

  // open-drain only pulls low and releases for a high
  always_comb begin
    pin_o      = level_i;
    pin_oe_n_o = ~(drive_i && !(od_i && level_i));
  end

  // pins are synchronous, one register is enough for a clean read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_o <= 1'b0;
    end else begin
      sample_o <= pin_i;
    end
  end

endmodule // sps_pin_cell

// >>> logic/sps_pin_select.sv
// pin function select for the six-pin port shared with two serial channels
//
// Overview of operation
// R01: bit5 is general I/O by direction when channel 1 async and both clock enables clear.
// R02: bit5 drives channel 1 clock if enable-high clear, sync or enable-low; input if enable-high.
// R03: any bit5 output is open-drain when its open-drain bit is one.
// R04: bit4 follows channel 0 settings the same way bit5 follows channel 1.
// R05: any bit4 output is open-drain when its open-drain bit is one.
// R06: bit3 is channel 1 receive input when receive enabled, else general I/O.
// R07: bit2 is channel 0 receive input when receive enabled, else general I/O.
// R08: bit2 general output is open-drain when its open-drain bit is one.
// R09: bit1 is channel 1 transmit output when enabled, else general; open-drain by its bit.
// R10: bit0 is channel 0 transmit output when enabled, else general I/O.
// R11: any bit0 output is open-drain when its open-drain bit is one.
// R12: direction one makes a general output from its data bit; zero makes input.
// R13: port read gives data bit for outputs and sampled pin level for inputs.
// R14: pin functions are recomputed combinationally from the current control bits.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/100ps
module sps_pin_select
  import sps_pkg::*;
(
  input  wire logic        clk_i,        // system clock, 125 MHz
  input  wire logic        rst_n_i,      // async reset, active low
  input  wire logic [3:0]  addr_i,       // register address
  input  wire logic [7:0]  wdata_i,      // write data
  input  wire logic        wr_i,         // write strobe
  input  wire logic        rd_i,         // read strobe
  output logic      [7:0]  rdata_o,      // read data, cycle after strobe
  input  wire logic [5:0]  pin_i,        // pin levels in
  output logic      [5:0]  pin_o,        // pin levels out
  output logic      [5:0]  pin_oe_n_o,   // output enables, low drives
  input  wire logic        chan0_serial_clock_i,  // channel 0 clock out value
  input  wire logic        chan1_serial_clock_i,  // channel 1 clock out value
  output logic             chan0_serial_clock_o,  // channel 0 clock from pin
  output logic             chan1_serial_clock_o,  // channel 1 clock from pin
  input  wire logic        tx0_data_i,   // channel 0 transmit data
  input  wire logic        tx1_data_i,   // channel 1 transmit data
  output logic             rx0_data_o,   // channel 0 receive data
  output logic             rx1_data_o    // channel 1 receive data
);

  // ****************************************
  // control registers
  // ****************************************
  logic [5:0] dir_q;        // bit5_direction .. bit0_direction
  logic [5:0] data_q;       // output data
  logic [5:0] odr_q;        // bit5_open_drain .. bit0_open_drain
  logic [4:0] ser0_q;       // channel 0 serial_mode_reg / serial_control_reg bits
  logic [4:0] ser1_q;       // channel 1 serial bits
  logic [5:0] sample;       // registered pin levels
  logic [5:0] drive;        // pin acts as output
  logic [5:0] level;        // level to drive
  logic [5:0] ser_own;      // pin taken by a serial function
  sps_clk_mode_e clk0_mode;
  sps_clk_mode_e clk1_mode;

  function automatic sps_clk_mode_e clk_mode(input logic [4:0] ser);
    if (ser[SPS_SER_CLOCK_ENABLE_HIGH]) begin
      clk_mode = SPS_CLK_IN;
    end else if (ser[SPS_SER_SYNC] || ser[SPS_SER_CLOCK_ENABLE_LOW]) begin
      clk_mode = SPS_CLK_OUT;
    end else begin
      clk_mode = SPS_CLK_GPIO;
    end
  endfunction

  // enable of a general pin: drives as output, except a released open-drain high
  function automatic logic gpio_oe_n(input logic dir, input logic od, input logic lvl);
    gpio_oe_n = !(dir && !(od && lvl));
  endfunction

  // register writes; direction is write only
  // serial bits live here too, so one write moves a pin between port and channel
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_q  <= SPS_DIR_RST;
      data_q <= SPS_DATA_RST;
      odr_q  <= SPS_ODR_RST;
      ser0_q <= SPS_SER_RST;
      ser1_q <= SPS_SER_RST;
    end else if (wr_i) begin
      case (addr_i)
        SPS_OFF_DIR:  dir_q  <= wdata_i[5:0];
        SPS_OFF_DATA: data_q <= wdata_i[5:0];
        SPS_OFF_ODR:  odr_q  <= wdata_i[5:0];
        SPS_OFF_SER0: ser0_q <= wdata_i[4:0];
        SPS_OFF_SER1: ser1_q <= wdata_i[4:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // function selection
  // ****************************************
  // pure logic so a control change acts at once on the pins  [R14]
  always_comb begin
    clk1_mode = clk_mode(ser1_q);  // [R01] [R02]
    clk0_mode = clk_mode(ser0_q);  // [R04]
    // general I/O default, data bit drives when direction is one  [R12]
    drive = dir_q;
    level = data_q;
    ser_own = 6'h00;
    // serial settings override direction; drive defaults survive on unowned pins only, level defaults also on serial input pins
    case (clk1_mode)
      SPS_CLK_OUT: begin
        drive[5] = 1'b1;  // [R02]
        level[5] = chan1_serial_clock_i;
        ser_own[5] = 1'b1;
      end
      SPS_CLK_IN: begin
        drive[5] = 1'b0;  // [R02]
        ser_own[5] = 1'b1;
      end
      default: ;
    endcase
    case (clk0_mode)
      SPS_CLK_OUT: begin
        drive[4] = 1'b1;  // [R04]
        level[4] = chan0_serial_clock_i;
        ser_own[4] = 1'b1;
      end
      SPS_CLK_IN: begin
        drive[4] = 1'b0;  // [R04]
        ser_own[4] = 1'b1;
      end
      default: ;
    endcase
    if (ser1_q[SPS_SER_RXEN]) begin
      drive[3] = 1'b0;  // [R06]
      ser_own[3] = 1'b1;
    end
    if (ser0_q[SPS_SER_RXEN]) begin
      drive[2] = 1'b0;  // [R07]
      ser_own[2] = 1'b1;
    end
    if (ser1_q[SPS_SER_TXEN]) begin
      drive[1] = 1'b1;  // [R09]
      level[1] = tx1_data_i;
      ser_own[1] = 1'b1;
    end
    if (ser0_q[SPS_SER_TXEN]) begin
      drive[0] = 1'b1;  // [R10]
      level[0] = tx0_data_i;
      ser_own[0] = 1'b1;
    end
  end

  // serial inputs see the raw pin; they stay in the channels' timing
  // limitation: nothing here filters glitches, the channels sample for themselves
  always_comb begin
    chan1_serial_clock_o = pin_i[5];
    chan0_serial_clock_o = pin_i[4];
    rx1_data_o           = pin_i[3];
    rx0_data_o           = pin_i[2];
  end

  // ****************************************
  // pin cells
  // ****************************************
  // every pin honours its open-drain bit whenever it drives  [R03] [R05] [R08] [R11]
  // cells are identical, so serial ownership only changes what feeds drive and level
  for (genvar g = 0; g < SPS_PINS; g++) begin : g_pin
    sps_pin_cell u_cell (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .drive_i    (drive[g]),
      .level_i    (level[g]),
      .od_i       (odr_q[g]),
      .pin_i      (pin_i[g]),
      .pin_o      (pin_o[g]),
      .pin_oe_n_o (pin_oe_n_o[g]),
      .sample_o   (sample[g])
    );
  end

  // ****************************************
  // read port
  // ****************************************
  // direction register reads as zero, it is write only
  // port reads carry the one-register sample lag: a pin change needs a cycle first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        SPS_OFF_DATA: rdata_o <= {2'b00, data_q};
        SPS_OFF_PORT: rdata_o <= {2'b00, (dir_q & data_q) | (~dir_q & sample)};  // [R13]
        SPS_OFF_ODR:  rdata_o <= {2'b00, odr_q};
        SPS_OFF_SER0: rdata_o <= {3'b000, ser0_q};
        SPS_OFF_SER1: rdata_o <= {3'b000, ser1_q};
        SPS_OFF_FUNC: rdata_o <= {2'b00, ser_own};
        default:      rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_bit5_gpio: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R01]
    (!ser1_q[SPS_SER_SYNC] && !ser1_q[SPS_SER_CLOCK_ENABLE_LOW] && !ser1_q[SPS_SER_CLOCK_ENABLE_HIGH])
      |-> (pin_oe_n_o[5] == !(dir_q[5] && !(odr_q[5] && data_q[5]))))
    else $error("bit5 general I/O drive wrong");
  chk_bit5_clkout: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R02]
    (!ser1_q[SPS_SER_CLOCK_ENABLE_HIGH] && (ser1_q[SPS_SER_SYNC] || ser1_q[SPS_SER_CLOCK_ENABLE_LOW]) && !odr_q[5])
      |-> (!pin_oe_n_o[5] && pin_o[5] == chan1_serial_clock_i))
    else $error("bit5 clock output not driven");
  chk_bit5_clkin: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R02]
    ser1_q[SPS_SER_CLOCK_ENABLE_HIGH] |-> pin_oe_n_o[5])
    else $error("bit5 driven while clock input");
  chk_bit5_opendrain: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R03]
    (odr_q[5] && pin_o[5]) |-> pin_oe_n_o[5])
    else $error("bit5 drives high in open-drain");
  chk_bit4_clkin: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R04]
    ser0_q[SPS_SER_CLOCK_ENABLE_HIGH] |-> pin_oe_n_o[4])
    else $error("bit4 driven while clock input");
  chk_bit4_opendrain: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R05]
    (odr_q[4] && pin_o[4]) |-> pin_oe_n_o[4])
    else $error("bit4 drives high in open-drain");
  chk_rx_pins_input: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R06] [R07]
    (ser1_q[SPS_SER_RXEN] |-> pin_oe_n_o[3]) and (ser0_q[SPS_SER_RXEN] |-> pin_oe_n_o[2]))
    else $error("receive pin driven");
  chk_bit2_opendrain: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R08]
    (odr_q[2] && pin_o[2]) |-> pin_oe_n_o[2])
    else $error("bit2 drives high in open-drain");
  chk_bit1_tx: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R09]
    (ser1_q[SPS_SER_TXEN] && !odr_q[1]) |-> (!pin_oe_n_o[1] && pin_o[1] == tx1_data_i))
    else $error("bit1 transmit not driven");
  chk_bit0_tx: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R10] [R11]
    ser0_q[SPS_SER_TXEN] |-> (pin_o[0] == tx0_data_i && pin_oe_n_o[0] == (odr_q[0] && tx0_data_i)))
    else $error("bit0 transmit drive wrong");
  chk_gpio_output: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R12]
    (ser0_q == 5'h00 && ser1_q == 5'h00 && dir_q == 6'h3f && odr_q == 6'h00)
      |-> (pin_oe_n_o == 6'h00 && pin_o == data_q))
    else $error("general output not driven from data");
  chk_port_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R13]
    (rd_i && addr_i == SPS_OFF_PORT)
      |=> (rdata_o[5:0] == (($past(dir_q) & $past(data_q)) | (~$past(dir_q) & $past(sample)))))
    else $error("port read value wrong");
  chk_ctrl_effect: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R14]
    (wr_i && addr_i == SPS_OFF_SER0 && wdata_i[SPS_SER_RXEN]) |=> pin_oe_n_o[2])
    else $error("control change not effective next cycle");

  // general side of bits 4 to 0 when their serial function is off, plus bit4 clock out, open-drain and receive routing
  chk_bit4_gpio: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R04]
    (!ser0_q[SPS_SER_SYNC] && !ser0_q[SPS_SER_CLOCK_ENABLE_LOW] && !ser0_q[SPS_SER_CLOCK_ENABLE_HIGH])
      |-> (pin_oe_n_o[4] == gpio_oe_n(dir_q[4], odr_q[4], data_q[4]) && pin_o[4] == data_q[4]))
    else $error("bit4 general I/O drive wrong");
  chk_bit4_clkout: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R04]
    (!ser0_q[SPS_SER_CLOCK_ENABLE_HIGH] && (ser0_q[SPS_SER_SYNC] || ser0_q[SPS_SER_CLOCK_ENABLE_LOW]) && !odr_q[4])
      |-> (!pin_oe_n_o[4] && pin_o[4] == chan0_serial_clock_i))
    else $error("bit4 clock output not driven");
  chk_bit3_gpio: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R06]
    !ser1_q[SPS_SER_RXEN]
      |-> (pin_oe_n_o[3] == gpio_oe_n(dir_q[3], odr_q[3], data_q[3]) && pin_o[3] == data_q[3]))
    else $error("bit3 general I/O drive wrong");
  chk_bit2_gpio: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R07] [R08]
    !ser0_q[SPS_SER_RXEN]
      |-> (pin_oe_n_o[2] == gpio_oe_n(dir_q[2], odr_q[2], data_q[2]) && pin_o[2] == data_q[2]))
    else $error("bit2 general I/O drive wrong");
  chk_bit1_gpio: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R09]
    !ser1_q[SPS_SER_TXEN]
      |-> (pin_oe_n_o[1] == gpio_oe_n(dir_q[1], odr_q[1], data_q[1]) && pin_o[1] == data_q[1]))
    else $error("bit1 general I/O drive wrong");
  chk_bit0_gpio: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R10] [R11]
    !ser0_q[SPS_SER_TXEN]
      |-> (pin_oe_n_o[0] == gpio_oe_n(dir_q[0], odr_q[0], data_q[0]) && pin_o[0] == data_q[0]))
    else $error("bit0 general I/O drive wrong");
  chk_bit1_opendrain: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R09]
    (odr_q[1] && pin_o[1]) |-> pin_oe_n_o[1])
    else $error("bit1 drives high in open-drain");
  chk_bit0_opendrain: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R11]
    (odr_q[0] && pin_o[0]) |-> pin_oe_n_o[0])
    else $error("bit0 drives high in open-drain");
  chk_rx_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R06] [R07]
    (ser1_q[SPS_SER_RXEN] && ser0_q[SPS_SER_RXEN]) |-> (rx1_data_o == pin_i[3] && rx0_data_o == pin_i[2]))
    else $error("receive data not routed from pin");

  // read data stand one cycle and are zero otherwise
  chk_read_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R13]
    !rd_i |=> (rdata_o == 8'h00))
    else $error("read data not zero when idle");
  chk_data_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R12]
    (rd_i && addr_i == SPS_OFF_DATA) |=> (rdata_o == {2'b00, $past(data_q)}))
    else $error("data register read wrong");
  chk_dir_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R12]
    (rd_i && addr_i == SPS_OFF_DIR) |=> (rdata_o == 8'h00))
    else $error("direction register not write only");
  chk_func_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // [R14]
    (rd_i && addr_i == SPS_OFF_FUNC) |=> (rdata_o == {2'b00, $past(ser_own)}))
    else $error("function read wrong");

  cov_clk_out:  cover property (@(posedge clk_i) disable iff (!rst_n_i) clk1_mode == SPS_CLK_OUT);
  cov_clk_in:   cover property (@(posedge clk_i) disable iff (!rst_n_i) clk0_mode == SPS_CLK_IN);
  cov_tx_od:    cover property (@(posedge clk_i) disable iff (!rst_n_i) ser1_q[SPS_SER_TXEN] && odr_q[1]);
  cov_port_rd:  cover property (@(posedge clk_i) disable iff (!rst_n_i) rd_i && addr_i == SPS_OFF_PORT);
  // both receive pins handed to the channels at once
  cov_rx_both:  cover property (@(posedge clk_i) disable iff (!rst_n_i) ser0_q[SPS_SER_RXEN] && ser1_q[SPS_SER_RXEN]);

endmodule // sps_pin_select

// >>> sim/sps_far_model.sv
// far-side model: resolves the six pin wires with pull-ups and an external driver
`timescale 1ns/100ps
module sps_far_model (
  input  wire logic [5:0] pin_o_i,     // levels the block drives
  input  wire logic [5:0] pin_oe_n_i,  // block enables, low drives
  input  wire logic [5:0] ext_en_i,    // external driver enables
  input  wire logic [5:0] ext_lvl_i,   // external driver levels
  output logic      [5:0] wire_o       // resolved wire levels
);
  // ****************************************
  // wire resolution
  // ****************************************
  // the block wins over the external driver so tests never see contention;
  // an undriven wire floats high through its pull-up, never holding a stale value
  always_comb begin
    for (int b = 0; b < 6; b++) begin
      if (!pin_oe_n_i[b]) begin
        wire_o[b] = pin_o_i[b];
      end else if (ext_en_i[b]) begin
        wire_o[b] = ext_lvl_i[b];
      end else begin
        wire_o[b] = 1'b1;
      end
    end
  end
endmodule // sps_far_model

// >>> sim/sps_pin_select_tb.sv
// self-checking testbench for the serial port pin select block
`timescale 1ns/100ps
module sps_pin_select_tb;
  import sps_pkg::*;
  logic       clk_i, rst_n_i, wr_i, rd_i, ck0, ck1, tx0, tx1;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic [5:0] pin_w, pin_o, pin_oe_n_o, ext_en, ext_lvl;
  logic       ck0_o, ck1_o, rx0_o, rx1_o;
  int         bad_count, checked;
  logic [4:0] modes [5] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05};
  int         kinds [5] = '{0, 1, 1, 2, 2};  // 0 general, 1 clock out, 2 clock in

  sps_pin_select i_sps_pin_select (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_w), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
    .chan0_serial_clock_i(ck0), .chan1_serial_clock_i(ck1), .chan0_serial_clock_o(ck0_o),
    .chan1_serial_clock_o(ck1_o), .tx0_data_i(tx0), .tx1_data_i(tx1), .rx0_data_o(rx0_o), .rx1_data_o(rx1_o));
  sps_far_model i_sps_far_model (.pin_o_i(pin_o), .pin_oe_n_i(pin_oe_n_o), .ext_en_i(ext_en),
    .ext_lvl_i(ext_lvl), .wire_o(pin_w));

  // ****************************************
  // clock, bus tasks and comparison
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // a write lands on the pins in the cycle after the strobe, so pins are looked at just past that edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    cmp(nm, exp, rdata_o);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // run-length guard
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    close_out();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    bad_count = 0; checked = 0; rst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 4'h0; wdata_i = 8'h00;
    ck0 = 1'b1; ck1 = 1'b1; tx0 = 1'b0; tx1 = 1'b1; ext_en = 6'h3f; ext_lvl = 6'h15;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    cmp("oe after reset", 8'h3f, {2'b00, pin_oe_n_o});
    rd_chk(SPS_OFF_DIR, 8'h00, "dir read");
    rd_chk(SPS_OFF_DATA, 8'h00, "data reset");
    rd_chk(SPS_OFF_ODR, 8'h00, "odr reset");
    rd_chk(SPS_OFF_SER1, 8'h00, "ser1 reset");
    rd_chk(4'hf, 8'h00, "unmapped");
    rd_chk(SPS_OFF_PORT, 8'h15, "port inputs");
    // general outputs on every pin, push-pull
    wr(SPS_OFF_DATA, 8'h2a);
    wr(SPS_OFF_DIR, 8'h3f);
    cmp("pin out", 8'h2a, {2'b00, pin_o});
    cmp("oe gpio", 8'h00, {2'b00, pin_oe_n_o});
    rd_chk(SPS_OFF_PORT, 8'h2a, "port outputs");
    @(posedge clk_i);
    #1;
    cmp("read data idle", 8'h00, rdata_o);
    // open-drain: ones release the wire to the far driver (low there), zeros pull low
    wr(SPS_OFF_ODR, 8'h3f);
    cmp("oe open drain", 8'h2a, {2'b00, pin_oe_n_o});
    cmp("wire open drain", 8'h00, {2'b00, pin_w});
    wr(SPS_OFF_ODR, 8'h00);
    wr(SPS_OFF_DATA, 8'h00);
    // clock pins through every mode with direction set
    for (int m = 0; m < 5; m++) begin
      wr(SPS_OFF_SER0, {3'b000, modes[m]});
      wr(SPS_OFF_SER1, {3'b000, modes[m]});
      cmp("clk pin oe", {2'b00, {2{kinds[m] == 2}}, 4'h0}, {2'b00, pin_oe_n_o});
      if (kinds[m] != 2) begin
        cmp("clk pin out", {2'b00, {2{kinds[m] == 1}}, 4'h0}, {2'b00, pin_o});
      end else begin
        cmp("clk in", 8'h01, {6'h00, ck1_o, ck0_o});
      end
    end
    // clock output under open-drain releases on a high clock
    wr(SPS_OFF_SER1, 8'h01);
    wr(SPS_OFF_ODR, 8'h20);
    // bit4 is still a clock input from the last mode of the loop
    cmp("clk open drain", 8'h30, {2'b00, pin_oe_n_o});
    // receive enables turn data pins into inputs
    wr(SPS_OFF_SER0, {3'b000, 5'h08});
    wr(SPS_OFF_SER1, {3'b000, 5'h08});
    cmp("rx oe", 8'h0c, {2'b00, pin_oe_n_o & 6'h0f});
    cmp("rx data", 8'h01, {6'h00, rx1_o, rx0_o});
    rd_chk(SPS_OFF_FUNC, 8'h0c, "func rx");
    // transmit enables route channel data to pins 0 and 1
    wr(SPS_OFF_ODR, 8'h00);
    wr(SPS_OFF_SER0, {3'b000, 5'h10});
    wr(SPS_OFF_SER1, {3'b000, 5'h10});
    cmp("tx out", 8'h02, {6'h00, pin_o[1:0]});
    cmp("tx oe", 8'h00, {6'h00, pin_oe_n_o[1:0]});
    wr(SPS_OFF_ODR, 8'h03);
    cmp("tx open drain", 8'h02, {6'h00, pin_oe_n_o[1:0]});
    rd_chk(SPS_OFF_SER0, 8'h10, "ser0 readback");
    // dropping the enables hands the pins back to direction bits
    wr(SPS_OFF_DIR, 8'h00);
    wr(SPS_OFF_SER0, 8'h00);
    wr(SPS_OFF_SER1, 8'h00);
    cmp("back to input", 8'h3f, {2'b00, pin_oe_n_o});
    close_out();
  end
endmodule // sps_pin_select_tb
